// >>> logic/bvdc_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none

`include "bvdc_defines.svh"

module bvdc_cpu_end (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link
    bvdc_link_if.cpu link,
    // Display byte source
    input wire logic [7:0] frame_byte,
    output logic byte_take,
    // Status
    output logic int_ack,
    output logic sync_error,
    output logic boundary_seen
);
    logic [2:0] phase_q;
    bvdc_pkg::bvdc_cycle_t kind_q;
    bvdc_pkg::bvdc_sc_t sc;
    logic int_busy_q;
    logic armed_q;
    logic [5:0] gap_q;
    logic [7:0] data_q;
    logic take_q, ack_q, err_q, seen_q;
    logic cycle_end;

    assign cycle_end = (phase_q == `BVDC_PH_LAST);

    // ----------------------------------------
    // Machine cycle timing
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end

    assign link.address_phase_pulse = (phase_q == `BVDC_PH_ADDR);
    assign link.data_strobe_pulse = (phase_q == `BVDC_PH_STROBE);

    // ----------------------------------------
    // Cycle selection
    // ----------------------------------------
    // Every non-DMA cycle is one machine cycle long, so a pending
    // DMA request is always honoured at the next boundary.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            kind_q <= bvdc_pkg::BVDC_CY_EXEC;
        end else if (cycle_end) begin
            if (!link.dma_out_request_n) begin
                kind_q <= bvdc_pkg::BVDC_CY_DMA;
            end else if (!link.irq_n && !int_busy_q) begin
                kind_q <= bvdc_pkg::BVDC_CY_INT;
            end else begin
                kind_q <= bvdc_pkg::BVDC_CY_EXEC;
            end
        end
    end

    always_comb begin
        case (kind_q)
            bvdc_pkg::BVDC_CY_DMA: sc = bvdc_pkg::BVDC_SC_DMA;
            bvdc_pkg::BVDC_CY_INT: sc = bvdc_pkg::BVDC_SC_INT;
            default: sc = bvdc_pkg::BVDC_SC_EXEC;
        endcase
    end

    assign link.state_code_bit_zero = sc[0];
    assign link.state_code_bit_one = sc[1];

    // Routine runs while the request is held, so no re-entry
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_busy_q <= 1'b0;
        end else if (cycle_end && !link.irq_n && !int_busy_q && link.dma_out_request_n) begin
            int_busy_q <= 1'b1;
        end else if (link.irq_n) begin
            int_busy_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Acknowledge-to-burst spacing check
    // ----------------------------------------
    // Counts whole cycles from the acknowledge to the first DMA cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed_q <= 1'b0;
            gap_q <= 6'h00;
            err_q <= 1'b0;
        end else begin
            err_q <= 1'b0;
            if (cycle_end) begin
                if (!link.dma_out_request_n) begin
                    if (armed_q && (gap_q + 6'h01 != `BVDC_INT_TO_DMA)) begin
                        err_q <= 1'b1;
                    end
                    armed_q <= 1'b0;
                end else if (!link.irq_n && !int_busy_q) begin
                    armed_q <= 1'b1;
                    gap_q <= 6'h00;
                end else if (armed_q) begin
                    gap_q <= gap_q + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Data bus and status
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_q <= 8'h00;
            take_q <= 1'b0;
            ack_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            take_q <= cycle_end && !link.dma_out_request_n;
            ack_q <= cycle_end && link.dma_out_request_n && !link.irq_n && !int_busy_q;
            seen_q <= ~link.window_boundary_flag_n;
            if (cycle_end && !link.dma_out_request_n) begin
                data_q <= frame_byte;
            end
        end
    end

    assign link.data_bus = data_q;
    assign byte_take = take_q;
    assign int_ack = ack_q;
    assign sync_error = err_q;
    assign boundary_seen = seen_q;
endmodule // bvdc_cpu_end

`default_nettype wire

// >>> logic/bvdc_defines.svh
`ifndef BVDC_DEFINES_SVH
`define BVDC_DEFINES_SVH

// ----------------------------------------
// Machine cycle framing
// ----------------------------------------
`define BVDC_MC_CLKS 4'h8
`define BVDC_PH_ADDR 3'h0
`define BVDC_PH_STROBE 3'h5
`define BVDC_PH_LAST 3'h7

// ----------------------------------------
// Line and field structure
// ----------------------------------------
`define BVDC_LINE_CYCLES 4'hE
`define BVDC_HSYNC_CYCLE 4'hC
`define BVDC_HSYNC_END 4'h1
`define BVDC_DMA_CYCLE 4'h1
`define BVDC_FIELD_LINES 9'h106
`define BVDC_VSYNC_LINES 9'h006
`define BVDC_DISP_FIRST 9'h050
`define BVDC_DISP_LINES 9'h080
`define BVDC_IRQ_LEAD 9'h002
`define BVDC_EDGE_LEAD 9'h004
`define BVDC_LINE_BYTES 4'h8
`define BVDC_INT_TO_DMA 6'h1D

`endif

// >>> logic/bvdc_device.sv
`timescale 1ns/1ps
`default_nettype none

`include "bvdc_defines.svh"

module bvdc_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link to the processor
    bvdc_link_if.dev link,
    // Monitor side
    output logic video,
    output logic comp_sync_n,
    // Status
    output logic field_tick,
    output logic in_window
);
    logic addr_pulse, strobe_pulse;
    bvdc_pkg::bvdc_sc_t sc;
    logic sc_sync_ok;
    logic [3:0] mc_q;
    logic [8:0] line_q;
    logic line_end;
    logic field_end;
    logic hsync_q;
    logic vsync;
    logic window;
    logic irq_zone;
    logic edge_zone;
    logic req_q;
    logic [3:0] left_q;
    logic [7:0] shreg_q;
    logic video_q;
    logic sync_n_q;
    logic tick_q;
    logic load;

    assign addr_pulse = link.address_phase_pulse;
    assign strobe_pulse = link.data_strobe_pulse;
    assign sc = bvdc_pkg::bvdc_sc_t'({link.state_code_bit_one, link.state_code_bit_zero});

    // Processor is in step when it is executing during hsync
    assign sc_sync_ok = (sc == bvdc_pkg::BVDC_SC_EXEC);

    // ----------------------------------------
    // Horizontal counter
    // ----------------------------------------
    // A line is 14 machine cycles; a processor out of step loses one
    // cycle at hsync, which pulls it back into line with the raster.
    assign line_end = addr_pulse && ((mc_q == `BVDC_LINE_CYCLES - 4'h1)
        || ((mc_q == `BVDC_HSYNC_CYCLE) && !sc_sync_ok));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mc_q <= 4'h0;
        end else if (line_end) begin
            mc_q <= 4'h0;
        end else if (addr_pulse) begin
            mc_q <= mc_q + 4'h1;
        end
    end

    // ----------------------------------------
    // Vertical counter
    // ----------------------------------------
    // Line 0 begins at the 262nd line pulse, so the field is always
    // whole lines with no half-line offset.
    assign field_end = line_end && (line_q == `BVDC_FIELD_LINES - 9'h001);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            line_q <= 9'h000;
        end else if (field_end) begin
            line_q <= 9'h000;
        end else if (line_end) begin
            line_q <= line_q + 9'h001;
        end
    end

    // ----------------------------------------
    // Sync generation
    // ----------------------------------------
    // Hsync starts at the strobe after the 13th address pulse and ends
    // on the second address pulse of the next line.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hsync_q <= 1'b0;
        end else if (strobe_pulse && (mc_q == `BVDC_HSYNC_CYCLE)) begin
            hsync_q <= 1'b1;
        end else if (addr_pulse && (mc_q == `BVDC_HSYNC_END - 4'h1)) begin
            hsync_q <= 1'b0;
        end
    end

    assign vsync = (line_q < `BVDC_VSYNC_LINES);

    // Exclusive-or keeps hsync edges inside vsync as serrations;
    // no equalizing pulses are produced.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_n_q <= 1'b1;
        end else begin
            sync_n_q <= ~(hsync_q ^ vsync);
        end
    end

    assign comp_sync_n = sync_n_q;

    // ----------------------------------------
    // Display window, interrupt and boundary flag
    // ----------------------------------------
    assign window = (line_q >= `BVDC_DISP_FIRST)
        && (line_q < `BVDC_DISP_FIRST + `BVDC_DISP_LINES);

    // Two whole lines, which is exactly 28 machine cycles
    assign irq_zone = (line_q >= `BVDC_DISP_FIRST - `BVDC_IRQ_LEAD)
        && (line_q < `BVDC_DISP_FIRST);

    // Four lines before the window opens and before it closes
    assign edge_zone = ((line_q >= `BVDC_DISP_FIRST - `BVDC_EDGE_LEAD) && (line_q < `BVDC_DISP_FIRST))
        || ((line_q >= `BVDC_DISP_FIRST + `BVDC_DISP_LINES - `BVDC_EDGE_LEAD)
        && (line_q < `BVDC_DISP_FIRST + `BVDC_DISP_LINES));

    assign link.irq_n_oe = irq_zone;
    assign link.window_boundary_flag_n = ~edge_zone;
    assign in_window = window;

    // Field tick doubles as a software time base
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= field_end;
        end
    end

    assign field_tick = tick_q;

    // ----------------------------------------
    // DMA request and byte loading
    // ----------------------------------------
    // Request opens on the second address pulse of the line, as hsync ends; the
    // processor's acknowledge spacing then lands the first burst
    // exactly 29 cycles after it.
    assign load = strobe_pulse && req_q && (sc == bvdc_pkg::BVDC_SC_DMA);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_q <= 1'b0;
            left_q <= 4'h0;
        end else if (addr_pulse && window && (mc_q == `BVDC_DMA_CYCLE - 4'h1)) begin
            req_q <= 1'b1;
            left_q <= `BVDC_LINE_BYTES;
        end else if (load) begin
            // Drop on the eighth strobe so no ninth cycle is taken
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
                req_q <= 1'b0;
            end
        end
    end

    assign link.dma_req_n_oe = req_q;

    // ----------------------------------------
    // Serializer
    // ----------------------------------------
    // A byte lasts exactly one machine cycle of 8 clocks, so eight
    // back-to-back bytes form one unbroken 64-spot line. Zeros fill in
    // behind, leaving the video dark once the register empties.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shreg_q <= 8'h00;
        end else if (load) begin
            shreg_q <= link.data_bus;
        end else begin
            shreg_q <= {shreg_q[6:0], 1'b0};
        end
    end

    // Bit value one drives a lit spot
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            video_q <= 1'b0;
        end else if (load) begin
            video_q <= link.data_bus[7];
        end else begin
            video_q <= shreg_q[6];
        end
    end

    assign video = video_q;
endmodule // bvdc_device

`default_nettype wire

// >>> logic/bvdc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bvdc_link_if (
    input wire logic sys_clk
);
    logic address_phase_pulse;
    logic data_strobe_pulse;
    logic state_code_bit_zero;
    logic state_code_bit_one;
    logic [7:0] data_bus;
    logic dma_req_n_oe;
    logic irq_n_oe;
    logic window_boundary_flag_n;
    // Open-drain lines with pull-ups
    logic dma_out_request_n;
    logic irq_n;

    assign dma_out_request_n = ~dma_req_n_oe;
    assign irq_n = ~irq_n_oe;

    modport dev (
        input address_phase_pulse, data_strobe_pulse, state_code_bit_zero, state_code_bit_one, data_bus,
        output dma_req_n_oe, irq_n_oe, window_boundary_flag_n
    );
    modport cpu (
        output address_phase_pulse, data_strobe_pulse, state_code_bit_zero, state_code_bit_one, data_bus,
        input dma_out_request_n, irq_n, window_boundary_flag_n
    );
endinterface

`default_nettype wire

// >>> logic/bvdc_pkg.sv
`default_nettype none

package bvdc_pkg;
    // State code carried by the processor in each machine cycle
    typedef enum logic [1:0] {
        BVDC_SC_FETCH = 2'h0,
        BVDC_SC_DMA = 2'h1,
        BVDC_SC_EXEC = 2'h2,
        BVDC_SC_INT = 2'h3
    } bvdc_sc_t;

    typedef enum {
        BVDC_CY_EXEC,
        BVDC_CY_DMA,
        BVDC_CY_INT
    } bvdc_cycle_t;
endpackage

`default_nettype wire

// >>> tb/bvdc_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module bvdc_link_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Processor timing and state
    input wire logic address_phase_pulse,
    input wire logic state_code_bit_zero,
    input wire logic state_code_bit_one,
    // Device requests and flag
    input wire logic dma_out_request_n,
    input wire logic irq_n,
    input wire logic window_boundary_flag_n
);
    logic [8:0] irq_lo_q;
    logic [8:0] flag_lo_q;
    logic dma_start;
    logic ack_start;

    assign dma_start = address_phase_pulse && !state_code_bit_one && state_code_bit_zero;
    assign ack_start = address_phase_pulse && state_code_bit_one && state_code_bit_zero;

    // Low-time counters; repetition would be far too long to unroll
    always_ff @(posedge sys_clk) begin
        irq_lo_q <= (rst || irq_n) ? 9'h000 : irq_lo_q + 9'h001;
    end

    always_ff @(posedge sys_clk) begin
        flag_lo_q <= (rst || window_boundary_flag_n) ? 9'h000 : flag_lo_q + 9'h001;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_irq_hold_len: assert property (
        $rose(irq_n) |-> irq_lo_q == 9'h0E0) else $error("interrupt request held for wrong time");
    a_irq_lead: assert property (
        $fell(irq_n) |-> flag_lo_q == 9'h0E0) else $error("interrupt request not two lines before window");
    a_irq_end_flag: assert property (
        $rose(irq_n) |-> $rose(window_boundary_flag_n)) else $error("interrupt and flag end apart");
    a_flag_len: assert property (
        $rose(window_boundary_flag_n) |-> flag_lo_q == 9'h1C0) else $error("boundary flag low for wrong time");
    a_req_len: assert property (
        $fell(dma_out_request_n) |-> ##69 $rose(dma_out_request_n)) else $error("request length wrong");
    a_ack_to_dma: assert property (
        ack_start |-> ##232 dma_start) else $error("first transfer not 29 cycles after acknowledge");
    a_dma_requested: assert property (
        dma_start |-> !dma_out_request_n) else $error("transfer cycle without request");
    a_ack_on_irq: assert property (
        ack_start |-> !irq_n) else $error("acknowledge without interrupt request");

    cover property ($rose(irq_n));
    cover property ($rose(dma_out_request_n));
    cover property (ack_start ##232 dma_start);
endmodule // bvdc_link_asserts

`default_nettype wire

// >>> tb/tb_bitmap_video_display_controller.sv
`timescale 1ns/1ps
`default_nettype none

module tb_bitmap_video_display_controller;
    logic sys_clk;
    logic rst;
    // Byte 0 of the pattern
    logic [7:0] frame_byte = 8'h25;
    logic byte_take;
    logic int_ack;
    logic sync_error;
    logic boundary_seen;
    logic video;
    logic comp_sync_n;
    logic field_tick;
    logic in_window;
    int n_fail;
    int n_checks;
    int cnt [9] = '{default: 0};
    int snap [9];
    int cyc = 0;
    int t0;
    int lo_run = 0;
    int last_req = -100000;
    int first_t = 0;
    int bad_gap = 0;
    logic [9:0] fed = 10'h000;
    logic [9:0] ld;
    logic [7:0] sh;
    logic csn_d = 1'b1;
    logic req_d = 1'b1;
    logic irq_d = 1'b1;
    logic flag_d = 1'b1;

    bvdc_link_if link (.sys_clk(sys_clk));

    bvdc_device bvdc_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .video(video),
        .comp_sync_n(comp_sync_n), .field_tick(field_tick), .in_window(in_window));

    bvdc_cpu_end bvdc_cpu_end_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .frame_byte(frame_byte),
        .byte_take(byte_take), .int_ack(int_ack), .sync_error(sync_error), .boundary_seen(boundary_seen));

    bvdc_link_asserts bvdc_link_asserts_inst (.sys_clk(sys_clk), .rst(rst),
        .address_phase_pulse(link.address_phase_pulse), .state_code_bit_zero(link.state_code_bit_zero),
        .state_code_bit_one(link.state_code_bit_one), .dma_out_request_n(link.dma_out_request_n),
        .irq_n(link.irq_n), .window_boundary_flag_n(link.window_boundary_flag_n));

    // Byte pattern varies with line and column so a slipped byte shows
    function automatic logic [7:0] pat(input logic [9:0] k);
        return k[7:0] ^ {k[9:8], 6'h25};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_tick();
        int i;
        for (i = 0; i < 30000; i++) begin
            @(negedge sys_clk);
            if (field_tick === 1'b1) begin
                break;
            end
        end
        if (i == 30000) begin
            n_fail++;
            results();
        end
        #1;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Expected video: loads seen on the link, shifted MSB first
    // ----------------------------------------
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rst) begin
            sh <= 8'h00;
            ld <= 10'h000;
        end else if (link.data_strobe_pulse && !link.state_code_bit_one && link.state_code_bit_zero
                     && !link.dma_out_request_n) begin
            sh <= pat(ld);
            ld <= ld + 10'h001;
        end else begin
            sh <= {sh[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Byte feed and event counting
    // ----------------------------------------
    always @(negedge sys_clk) begin
        if (!rst) begin
            check({31'h0, video}, {31'h0, sh[7]});
            check({31'h0, boundary_seen}, {31'h0, ~flag_d});
            if (byte_take === 1'b1) begin
                fed = fed + 10'h001;
                frame_byte <= pat(fed);
            end
            cnt[1] += int'(byte_take);
            cnt[6] += int'(int_ack);
            cnt[7] += int'(sync_error);
            cnt[8] += int'(in_window);
            if (csn_d && !comp_sync_n) cnt[2]++;
            if (!csn_d && comp_sync_n && lo_run > 56) cnt[3]++;
            if (irq_d && !link.irq_n) cnt[4]++;
            if (req_d && !link.dma_out_request_n) begin
                cnt[5]++;
                if (cyc - last_req >= 224) begin
                    if (first_t != 0) check(cyc - first_t, 29344);
                    first_t = cyc;
                end else if (cyc - last_req != 112) begin
                    bad_gap++;
                end
                last_req = cyc;
            end
        end
        lo_run = (comp_sync_n === 1'b0) ? lo_run + 1 : 0;
        csn_d = comp_sync_n;
        req_d = link.dma_out_request_n;
        irq_d = link.irq_n;
        flag_d = link.window_boundary_flag_n;
    end

    initial begin
        rst = 1'b1;
        n_fail = 0;
        n_checks = 0;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        wait_tick();
        snap = cnt;
        t0 = cyc;
        wait_tick();
        check(cyc - t0, 29344);
        check(cnt[1] - snap[1], 1024);
        // One fall per line, plus the one where vsync ends under high hsync
        check(cnt[2] - snap[2], 263);
        check(cnt[3] - snap[3], 6);
        check(cnt[4] - snap[4], 1);
        check(cnt[5] - snap[5], 128);
        check(cnt[6] - snap[6], 1);
        check(cnt[7] - snap[7], 0);
        check(cnt[8] - snap[8], 14336);
        check(bad_gap, 0);
        results();
    end
endmodule // tb_bitmap_video_display_controller

`default_nettype wire
